// ==== ext_key_addr_match_irq.sv ====
// Purpose: Interrupt request sources and priority judgement
// Assumes: Single 25 MHz clock; pins and CPU signals synchronous
// Notes:   Grant is the highest unmasked requesting source; CPU acknowledges it
`timescale 1ns/100ps
`default_nettype none
module ext_key_addr_match_irq (
   input  wire logic                                  ref_clk,
   input  wire logic                                  rst,
   input  wire logic [irq_pkg::EXT_PINS-1:0]          extIrqPin,
   input  wire irq_pkg::ext_cfg_type [irq_pkg::EXT_PINS-1:0] extCfg,
   input  wire logic [irq_pkg::EXT_PINS-1:0]          extFlagClear,
   input  wire logic [irq_pkg::EXT_PINS-1:0][irq_pkg::LEVEL_W-1:0] extLevel,
   input  wire logic [irq_pkg::KEY_PINS-1:0]          keyPin,
   input  wire irq_pkg::key_cfg_type [irq_pkg::KEY_PINS-1:0] keyCfg,
   input  wire logic                                  keyFlagClear,
   input  wire logic [irq_pkg::LEVEL_W-1:0]           keyLevel,
   input  wire irq_pkg::match_cfg_type [irq_pkg::MATCH_UNITS-1:0] matchCfg,
   input  wire logic [irq_pkg::ADDR_W-1:0]            fetchAddress,
   input  wire logic                                  fetchValid,
   input  wire logic                                  fetchShortForm,
   input  wire logic                                  globalEnable,
   input  wire logic [irq_pkg::LEVEL_W-1:0]           processorPriorityLevel,
   input  wire logic                                  cpuAck,
   input  wire logic                                  sleeping,
   output logic [irq_pkg::SRC_N-1:0]                  requestFlag,
   output irq_pkg::grant_type                         grant,
   output logic [irq_pkg::ADDR_W-1:0]                 stackedAddress,
   output logic                                       wakeUp
);

   // ------------------------------------------------------------------
   // Sampling clock divider
   // ------------------------------------------------------------------
   logic [irq_pkg::DIV_W-1:0] divCount;
   logic [irq_pkg::DIV_W-1:0] next_divCount;
   logic                      tick8;
   logic                      tick32;

   always_comb begin
      next_divCount = divCount + 1'b1;
   end

   assign tick8  = (divCount & irq_pkg::DIV8_MASK) == irq_pkg::DIV_ZERO;
   assign tick32 = (divCount & irq_pkg::DIV32_MASK) == irq_pkg::DIV_ZERO;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         divCount <= irq_pkg::DIV_ZERO;
      end else begin
         divCount <= next_divCount;
      end
   end

   // Sample enable for a two-bit select; decoded per pin
   function automatic logic sample_enable(input logic [1:0] sel,
                                          input logic t8,
                                          input logic t32);
      case (sel)
         irq_pkg::FSEL_DIV1:  sample_enable = 1'b1;
         irq_pkg::FSEL_DIV8:  sample_enable = t8;
         irq_pkg::FSEL_DIV32: sample_enable = t32;
         default:             sample_enable = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // External pin filters
   // ------------------------------------------------------------------
   logic [irq_pkg::EXT_PINS-1:0] extEdge;
   logic [irq_pkg::EXT_PINS-1:0] extBypass;
   logic [irq_pkg::EXT_PINS-1:0] extSample;
   logic                         pin4BothLast;
   logic                         pin4Spurious;

   genvar p;
   generate
      for (p = 0; p < irq_pkg::EXT_PINS; p++) begin : g_ext
         assign extBypass[p] = (extCfg[p].filterSel == irq_pkg::FSEL_NONE);
         assign extSample[p] = sample_enable(extCfg[p].filterSel,
                                             tick8, tick32);
         ext_pin_filter u_filter (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .pinLevel (extIrqPin[p]),
            .sampleEn (extSample[p]),
            .bypass   (extBypass[p]),
            .cfg      (extCfg[p]),
            .edgeSeen (extEdge[p])
         );
      end
   endgenerate

   // Changing the both-edge select is treated as an edge for pin 4
   assign pin4Spurious =
      extCfg[irq_pkg::PIN4_LANE].bothEdge != pin4BothLast;

   // ------------------------------------------------------------------
   // Key input unit
   // ------------------------------------------------------------------
   logic keyEvent;

   key_input_unit u_key (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .keyPin   (keyPin),
      .cfg      (keyCfg),
      .keyEvent (keyEvent)
   );

   // ------------------------------------------------------------------
   // Address compare
   // ------------------------------------------------------------------
   logic [irq_pkg::MATCH_UNITS-1:0] matchHit;

   genvar m;
   generate
      for (m = 0; m < irq_pkg::MATCH_UNITS; m++) begin : g_match
         assign matchHit[m] = fetchValid && matchCfg[m].enable &&
                              fetchAddress == matchCfg[m].address;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Request flags, judgement and stacked address
   // ------------------------------------------------------------------
   logic [irq_pkg::SRC_N-1:0] setReq;
   logic [irq_pkg::SRC_N-1:0] clearReq;
   logic [irq_pkg::SRC_N-1:0] next_requestFlag;
   irq_pkg::grant_type        next_grant;
   logic [irq_pkg::ADDR_W-1:0] next_stackedAddress;
   logic [irq_pkg::ADDR_W-1:0] matchAddrLatch0;
   logic [irq_pkg::ADDR_W-1:0] matchAddrLatch1;
   logic [1:0]                shortForm;
   logic [1:0]                next_shortForm;
   logic [irq_pkg::ADDR_W-1:0] next_matchAddrLatch0;
   logic [irq_pkg::ADDR_W-1:0] next_matchAddrLatch1;
   logic                      next_wakeUp;

   function automatic logic [irq_pkg::LEVEL_W-1:0] src_level(
      input int s,
      input logic [irq_pkg::EXT_PINS-1:0][irq_pkg::LEVEL_W-1:0] el,
      input logic [irq_pkg::LEVEL_W-1:0] kl);
      if (s < irq_pkg::EXT_PINS) begin
         src_level = el[s];
      end else begin
         src_level = kl;
      end
   endfunction

   always_comb begin
      int s;
      irq_pkg::grant_type best;
      s    = 0;
      best = '0;
      best.source = irq_pkg::NO_SOURCE;
      setReq   = {matchHit, keyEvent, extEdge};
      setReq[irq_pkg::PIN4_LANE] = extEdge[irq_pkg::PIN4_LANE] |
                                   pin4Spurious;
      clearReq = {2'b00, keyFlagClear, extFlagClear};
      // Acknowledge clears only the granted source
      if (cpuAck && grant.valid) begin
         clearReq[grant.source] = 1'b1;
      end
      next_requestFlag = (requestFlag & ~clearReq) | setReq;
      // Non-maskable address match has top priority, unit 0 first
      if (requestFlag[irq_pkg::SRC_MATCH0]) begin
         best.valid       = 1'b1;
         best.source      = irq_pkg::SRC_W'(irq_pkg::SRC_MATCH0);
         best.nonMaskable = 1'b1;
      end else if (requestFlag[irq_pkg::SRC_MATCH1]) begin
         best.valid       = 1'b1;
         best.source      = irq_pkg::SRC_W'(irq_pkg::SRC_MATCH1);
         best.nonMaskable = 1'b1;
      end else if (globalEnable) begin
         // Lower index wins a tie, so scan downward with >=
         for (s = irq_pkg::SRC_KEY; s >= 0; s--) begin
            if (requestFlag[s] &&
                src_level(s, extLevel, keyLevel) > processorPriorityLevel &&
                (!best.valid ||
                 src_level(s, extLevel, keyLevel) >= best.level)) begin
               best.valid  = 1'b1;
               best.source = irq_pkg::SRC_W'(s);
               best.level  = src_level(s, extLevel, keyLevel);
            end
         end
      end
      // Ack in flight: withdraw grant so it is not taken twice
      if (cpuAck) begin
         best = '0;
         best.source = irq_pkg::NO_SOURCE;
      end
      next_grant = best;
      next_shortForm       = shortForm;
      next_matchAddrLatch0 = matchAddrLatch0;
      next_matchAddrLatch1 = matchAddrLatch1;
      if (matchHit[0]) begin
         next_matchAddrLatch0 = matchCfg[0].address;
         next_shortForm[0]    = fetchShortForm;
      end
      if (matchHit[1]) begin
         next_matchAddrLatch1 = matchCfg[1].address;
         next_shortForm[1]    = fetchShortForm;
      end
      next_stackedAddress = stackedAddress;
      if (best.valid && best.source == irq_pkg::SRC_W'(irq_pkg::SRC_MATCH0)) begin
         next_stackedAddress = matchAddrLatch0 + (shortForm[0] ?
            irq_pkg::SHORT_OP_OFFSET : irq_pkg::LONG_OP_OFFSET);
      end else if (best.valid &&
                   best.source == irq_pkg::SRC_W'(irq_pkg::SRC_MATCH1)) begin
         next_stackedAddress = matchAddrLatch1 + (shortForm[1] ?
            irq_pkg::SHORT_OP_OFFSET : irq_pkg::LONG_OP_OFFSET);
      end
      next_wakeUp = sleeping && next_requestFlag[irq_pkg::SRC_KEY];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         requestFlag     <= '0;
         grant           <= '{valid: 1'b0, source: irq_pkg::NO_SOURCE,
                              level: irq_pkg::LEVEL_ZERO, nonMaskable: 1'b0};
         stackedAddress  <= irq_pkg::ADDR_ZERO;
         matchAddrLatch0 <= irq_pkg::ADDR_ZERO;
         matchAddrLatch1 <= irq_pkg::ADDR_ZERO;
         shortForm       <= 2'b00;
         pin4BothLast    <= 1'b0;
         wakeUp          <= 1'b0;
      end else begin
         requestFlag     <= next_requestFlag;
         grant           <= next_grant;
         stackedAddress  <= next_stackedAddress;
         matchAddrLatch0 <= next_matchAddrLatch0;
         matchAddrLatch1 <= next_matchAddrLatch1;
         shortForm       <= next_shortForm;
         pin4BothLast    <= extCfg[irq_pkg::PIN4_LANE].bothEdge;
         wakeUp          <= next_wakeUp;
      end
   end

endmodule
`default_nettype wire

// ==== ext_pin_filter.sv ====
// Purpose: Digital filter and edge detector for one external pin
// Assumes: sampleEn is held high, or a one-cycle pulse from a shared divider
// Notes:   Reports an edge pulse; the flag lives in the top module
`timescale 1ns/100ps
`default_nettype none
module ext_pin_filter (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               pinLevel,
   input  wire logic               sampleEn,
   input  wire logic               bypass,
   input  wire irq_pkg::ext_cfg_type cfg,
   output logic                    edgeSeen
);

   logic                        lastSample;
   logic                        next_lastSample;
   logic [irq_pkg::CNT_W-1:0]   agree;
   logic [irq_pkg::CNT_W-1:0]   next_agree;
   logic                        filtered;
   logic                        next_filtered;
   logic                        next_edgeSeen;

   // ------------------------------------------------------------------
   // Sampling, agreement count and edge decision
   // ------------------------------------------------------------------
   always_comb begin
      next_lastSample = lastSample;
      next_agree      = agree;
      next_filtered   = filtered;
      next_edgeSeen   = 1'b0;
      if (bypass) begin
         next_filtered   = pinLevel;
         next_lastSample = pinLevel;
         next_agree      = '0;
      end else if (sampleEn) begin
         next_lastSample = pinLevel;
         if (pinLevel != lastSample) begin
            next_agree = '0;
         end else if (agree < irq_pkg::CNT_W'(irq_pkg::FILT_AGREE - 1)) begin
            next_agree = agree + 1'b1;
         end
         // Third matching sample commits the level
         if (pinLevel == lastSample &&
             agree == irq_pkg::CNT_W'(irq_pkg::FILT_AGREE - 2)) begin
            next_filtered = pinLevel;
         end
      end
      // Edge on the filtered level, polarity or both edges
      if (next_filtered != filtered && cfg.enable) begin
         if (cfg.bothEdge) begin
            next_edgeSeen = 1'b1;
         end else begin
            next_edgeSeen = (next_filtered == cfg.polarity);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lastSample <= 1'b1;
         agree      <= '0;
         filtered   <= 1'b1;
         edgeSeen   <= 1'b0;
      end else begin
         lastSample <= next_lastSample;
         agree      <= next_agree;
         filtered   <= next_filtered;
         edgeSeen   <= next_edgeSeen;
      end
   end

endmodule
`default_nettype wire

// ==== irq_checker.sv ====
// Purpose: Concurrent checks on the request, grant and wake outputs
// Assumes: Bound to the top module; one clock domain
// Notes:   Match timing follows fetch, flag, grant on three edges
`timescale 1ns/100ps
`default_nettype none
module irq_checker (
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst,
   input  wire irq_pkg::ext_cfg_type [irq_pkg::EXT_PINS-1:0] extCfg,
   input  wire irq_pkg::match_cfg_type [irq_pkg::MATCH_UNITS-1:0] matchCfg,
   input  wire logic [irq_pkg::ADDR_W-1:0]             fetchAddress,
   input  wire logic                                   fetchValid,
   input  wire logic                                   fetchShortForm,
   input  wire logic                                   globalEnable,
   input  wire logic [irq_pkg::LEVEL_W-1:0]            processorPriorityLevel,
   input  wire logic                                   cpuAck,
   input  wire logic                                   sleeping,
   input  wire logic [irq_pkg::SRC_N-1:0]              requestFlag,
   input  wire irq_pkg::grant_type                     grant,
   input  wire logic [irq_pkg::ADDR_W-1:0]             stackedAddress,
   input  wire logic                                   wakeUp
);
   logic hit0;
   assign hit0 = fetchValid && matchCfg[0].enable
                 && fetchAddress == matchCfg[0].address;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_grant0;
      grant.valid && grant.source == irq_pkg::SRC_MATCH0;
   endsequence
   sequence s_short0;
      hit0 && fetchShortForm ##2 s_grant0;
   endsequence
   sequence s_long0;
      hit0 && !fetchShortForm ##2 s_grant0;
   endsequence
   a_match_sets: assert property (hit0 |=> requestFlag[5])
      else $error("match hit gave no flag");
   a_match_quiet: assert property (!requestFlag[5] && !hit0 |=> !requestFlag[5])
      else $error("match flag without a hit");
   a_match_grant: assert property ($rose(requestFlag[5]) && !cpuAck |=> s_grant0)
      else $error("match flag not granted");
   a_stack_short: assert property (s_short0 |-> stackedAddress
      == $past(fetchAddress, 2) + irq_pkg::SHORT_OP_OFFSET)
      else $error("short form stacked value");
   a_stack_long: assert property (s_long0 |-> stackedAddress
      == $past(fetchAddress, 2) + irq_pkg::LONG_OP_OFFSET)
      else $error("long form stacked value");
   a_ack_drops: assert property (cpuAck && grant.valid |=> !grant.valid)
      else $error("grant stayed after ack");
   a_ack_clears: assert property (cpuAck && grant.valid && !hit0
      && grant.source == irq_pkg::SRC_MATCH0 |=> !requestFlag[5])
      else $error("match flag stayed after ack");
   a_mask_gate: assert property (grant.valid && !grant.nonMaskable
      |-> $past(globalEnable)
      && grant.level > $past(processorPriorityLevel))
      else $error("maskable grant while masked");
   a_wake_key: assert property (sleeping ##1 requestFlag[4] |-> wakeUp)
      else $error("no wake on key request");
   a_ext_off: assert property ((!extCfg[0].enable) [*4]
      |=> !$rose(requestFlag[0]))
      else $error("disabled pin raised flag");
endmodule
`default_nettype wire

// ==== irq_partner.sv ====
// Purpose: CPU side that accepts whatever request is granted
// Assumes: Grant settles after the rising edge
// Notes:   ackDelay valid cycles pass before the one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module irq_partner (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire irq_pkg::grant_type grant,
   input  wire logic               ackOn,
   input  wire logic [3:0]         ackDelay,
   output logic                    cpuAck
);
   logic [3:0] waitCount;
   // Changes on the falling edge so the design samples a settled ack
   always_ff @(negedge ref_clk or posedge rst) begin
      if (rst) begin
         cpuAck <= 1'b0;
         waitCount <= 4'h0;
      end else if (cpuAck || !grant.valid || !ackOn) begin
         cpuAck <= 1'b0;
         waitCount <= 4'h0;
      end else if (waitCount == ackDelay) begin
         cpuAck <= 1'b1;
      end else begin
         waitCount <= waitCount + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== irq_pkg.sv ====
// Purpose: Shared constants and carrier types for the interrupt source block
// Assumes: One 25 MHz clock, synchronous pin inputs
// Notes:   Filter sample rates are divider enables, not separate clocks
package irq_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int EXT_PINS     = 4;   // Pins 0, 1, 2, 4 in lane order
   localparam int KEY_PINS     = 4;
   localparam int MATCH_UNITS  = 2;
   localparam int ADDR_W       = 20;
   localparam int LEVEL_W      = 3;
   localparam int SRC_N        = 7;   // Ext 0..3, key, match 0, match 1
   localparam int SRC_W        = 3;
   localparam int FILT_AGREE   = 3;
   localparam int CNT_W        = 2;
   localparam int DIV_W        = 5;

   // ------------------------------------------------------------------
   // Source indices and encodings
   // ------------------------------------------------------------------
   localparam int SRC_KEY      = 4;
   localparam int SRC_MATCH0   = 5;
   localparam int SRC_MATCH1   = 6;
   localparam int PIN4_LANE    = 3;

   localparam logic [SRC_W-1:0] NO_SOURCE = 3'h7;

   // Filter sample enable dividers: 0 selects no filter
   localparam logic [1:0] FSEL_NONE = 2'h0;
   localparam logic [1:0] FSEL_DIV1 = 2'h1;
   localparam logic [1:0] FSEL_DIV8 = 2'h2;
   localparam logic [1:0] FSEL_DIV32 = 2'h3;
   localparam logic [DIV_W-1:0] DIV8_MASK  = 5'h07;
   localparam logic [DIV_W-1:0] DIV32_MASK = 5'h1F;
   localparam logic [DIV_W-1:0] DIV_ZERO   = 5'h00;

   // Stacked address offsets for address match
   localparam logic [ADDR_W-1:0] SHORT_OP_OFFSET = 20'h0_0002;
   localparam logic [ADDR_W-1:0] LONG_OP_OFFSET  = 20'h0_0001;
   localparam logic [ADDR_W-1:0] ADDR_ZERO       = 20'h0_0000;
   localparam logic [LEVEL_W-1:0] LEVEL_ZERO     = 3'h0;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       enable;      // Per-pin enable
      logic       bothEdge;    // Both-edge select
      logic       polarity;    // 0 falling, 1 rising
      logic [1:0] filterSel;   // Sampling clock select
   } ext_cfg_type;

   typedef struct packed {
      logic enable;
      logic polarity;          // 0 falling, 1 rising
   } key_cfg_type;

   typedef struct packed {
      logic              enable;
      logic [ADDR_W-1:0] address;
   } match_cfg_type;

   typedef struct packed {
      logic              valid;
      logic [SRC_W-1:0]  source;
      logic [LEVEL_W-1:0] level;
      logic              nonMaskable;
   } grant_type;

endpackage

// ==== key_input_unit.sv ====
// Purpose: Four key pins sharing one interrupt request
// Assumes: Key pins are synchronous to ref_clk
// Notes:   Combinational wake output is avoided; wake is registered
`timescale 1ns/100ps
`default_nettype none
module key_input_unit (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic [irq_pkg::KEY_PINS-1:0]  keyPin,
   input  wire irq_pkg::key_cfg_type [irq_pkg::KEY_PINS-1:0] cfg,
   output logic                               keyEvent
);

   logic [irq_pkg::KEY_PINS-1:0] active;
   logic [irq_pkg::KEY_PINS-1:0] prevActive;
   logic                         next_keyEvent;

   // ------------------------------------------------------------------
   // Active level per pin
   // ------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < irq_pkg::KEY_PINS; k++) begin : g_key
         // Active means enabled and at the selected level
         assign active[k] = cfg[k].enable &&
                            (keyPin[k] == cfg[k].polarity);
      end
   endgenerate

   // A pin already held active blocks the shared request (wired gate)
   always_comb begin
      next_keyEvent = 1'b0;
      if ((active & ~prevActive) != '0 && prevActive == '0) begin
         next_keyEvent = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prevActive <= '0;
         keyEvent   <= 1'b0;
      end else begin
         prevActive <= active;
         keyEvent   <= next_keyEvent;
      end
   end

endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Directed scenarios for the interrupt source block
// Assumes: Inputs change on the falling edge
// Notes:   Flag waits are bounded; a spent bound ends the run
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk, rst, keyFlagClear, fetchValid, fetchShortForm;
   logic globalEnable, cpuAck, sleeping, ackOn, wakeUp;
   logic [3:0] extIrqPin, extFlagClear, keyPin, ackDelay;
   logic [3:0][2:0] extLevel;
   logic [2:0] keyLevel, processorPriorityLevel;
   logic [19:0] fetchAddress, stackedAddress;
   logic [6:0] requestFlag;
   irq_pkg::ext_cfg_type [3:0] extCfg;
   irq_pkg::key_cfg_type [3:0] keyCfg;
   irq_pkg::match_cfg_type [1:0] matchCfg;
   irq_pkg::grant_type grant;
   int mismatches, checked;
   ext_key_addr_match_irq ext_key_addr_match_irq_i (.ref_clk(ref_clk),
      .rst(rst), .extIrqPin(extIrqPin), .extCfg(extCfg),
      .extFlagClear(extFlagClear), .extLevel(extLevel), .keyPin(keyPin),
      .keyCfg(keyCfg), .keyFlagClear(keyFlagClear), .keyLevel(keyLevel),
      .matchCfg(matchCfg), .fetchAddress(fetchAddress),
      .fetchValid(fetchValid), .fetchShortForm(fetchShortForm),
      .globalEnable(globalEnable), .cpuAck(cpuAck), .sleeping(sleeping),
      .processorPriorityLevel(processorPriorityLevel),
      .requestFlag(requestFlag), .grant(grant),
      .stackedAddress(stackedAddress), .wakeUp(wakeUp));
   irq_partner irq_partner_i (.ref_clk(ref_clk), .rst(rst), .grant(grant),
      .ackOn(ackOn), .ackDelay(ackDelay), .cpuAck(cpuAck));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [19:0] e, g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wait_flag(input int i, input logic v, input int lim);
      int k;
      k = 0;
      while (requestFlag[i] !== v && k < lim) begin
         tick(1);
         k++;
      end
      chk("flag wait", v, requestFlag[i]);
      if (requestFlag[i] !== v) finish_test();
   endtask
   // Settle first: a clear in the cycle of a set would lose to the set
   task automatic clr(input int i);
      tick(3);
      if (i == 4) keyFlagClear = 1'b1;
      else extFlagClear[i] = 1'b1;
      tick(1);
      keyFlagClear = 1'b0;
      extFlagClear = 4'h0;
      tick(1);
   endtask
   task automatic fetch(input logic [19:0] a, input logic s);
      fetchAddress = a;
      fetchShortForm = s;
      fetchValid = 1'b1;
      tick(1);
      fetchValid = 1'b0;
   endtask
   task automatic t_match;
      logic [19:0] a, e;
      globalEnable = 1'b0;
      processorPriorityLevel = 3'h7;
      for (int u = 0; u < 4; u++) begin
         a = 20'h4_5670 + 20'(u * 16);
         e = a + (u > 1 ? irq_pkg::SHORT_OP_OFFSET : irq_pkg::LONG_OP_OFFSET);
         matchCfg = '0;
         matchCfg[u % 2] = '{1'b1, a};
         ackDelay = 4'(u * 3);
         fetch(a + 20'h0_0001, 1'b0);
         tick(3);
         chk("other address", 0, requestFlag[6:5]);
         fetch(a, u > 1);
         wait_flag(5 + u % 2, 1'b1, 4);
         tick(1);
         chk("match source", 20'(5 + u % 2), grant.source);
         chk("stacked", e, stackedAddress);
         ackOn <= 1'b1;
         wait_flag(5 + u % 2, 1'b0, 16);
         ackOn <= 1'b0;
         matchCfg[u % 2].enable = 1'b0;
         fetch(a, 1'b0);
         tick(3);
         chk("disabled unit", 0, requestFlag[6:5]);
      end
      $display("t_match done");
   endtask
   task automatic t_ext;
      int dv;
      for (int l = 0; l < 4; l++) begin
         dv = (l < 2) ? 1 : (l == 2) ? 8 : 32;
         extLevel[l] = 3'(l + 2);
         extCfg[l] = '{1'b0, 1'b0, 1'b0, 2'(l)};
         extIrqPin[l] = 1'b0;
         tick(3 * dv + 6);
         chk("disabled pin", 0, requestFlag[l]);
         extIrqPin[l] = 1'b1;
         tick(3 * dv + 6);
         extCfg[l].enable = 1'b1;
         if (l > 0) begin
            extIrqPin[l] = 1'b0;
            tick(2 * dv);
            extIrqPin[l] = 1'b1;
            tick(3 * dv + 6);
            chk("short pulse", 0, requestFlag[l]);
         end
         extIrqPin[l] = 1'b0;
         tick(2 * dv - 1);
         chk("early flag", 0, requestFlag[l]);
         wait_flag(l, 1'b1, 3 * dv + 6);
         globalEnable = 1'b0;
         processorPriorityLevel = 3'(l + 1);
         tick(2);
         chk("masked grant", 0, grant.valid);
         globalEnable = 1'b1;
         tick(2);
         chk("ext source", 20'(l), grant.source);
         processorPriorityLevel = 3'(l + 2);
         tick(2);
         chk("level gate", 0, grant.valid);
         extIrqPin[l] = 1'b1;
      end
      processorPriorityLevel = 3'h0;
      tick(2);
      chk("highest source", 3, grant.source);
      extFlagClear = 4'hF;
      tick(1);
      extFlagClear = 4'h0;
      tick(2);
      chk("cleared flags", 0, requestFlag[3:0]);
      $display("t_ext done");
   endtask
   task automatic t_pin4;
      extCfg[3] = '{1'b1, 1'b0, 1'b0, irq_pkg::FSEL_NONE};
      clr(3);
      extCfg[3].bothEdge = 1'b1;
      wait_flag(3, 1'b1, 4);
      for (int e = 0; e < 2; e++) begin
         clr(3);
         extIrqPin[3] = 1'(e);
         wait_flag(3, 1'b1, 6);
      end
      extCfg[3] = '{1'b1, 1'b0, 1'b1, irq_pkg::FSEL_NONE};
      clr(3);
      extIrqPin[3] = 1'b0;
      tick(6);
      chk("rising only", 0, requestFlag[3]);
      extIrqPin[3] = 1'b1;
      wait_flag(3, 1'b1, 6);
      clr(3);
      $display("t_pin4 done");
   endtask
   task automatic t_key;
      keyLevel = 3'h1;
      sleeping = 1'b1;
      keyPin[0] = 1'b0;
      wait_flag(4, 1'b1, 6);
      tick(1);
      chk("wake", 1, wakeUp);
      clr(4);
      keyPin[1] = 1'b0;
      tick(6);
      chk("blocked key", 0, requestFlag[4]);
      keyPin[1:0] = 2'b11;
      tick(6);
      chk("wrong edge", 0, requestFlag[4]);
      keyPin[3] = 1'b1;
      wait_flag(4, 1'b1, 6);
      keyPin[3] = 1'b0;
      clr(4);
      keyCfg[2].enable = 1'b0;
      keyPin[2] = 1'b0;
      tick(6);
      chk("disabled key", 0, requestFlag[4]);
      sleeping = 1'b0;
      $display("t_key done");
   endtask
   initial begin
      mismatches = 0;
      checked = 0;
      rst = 1'b1;
      {keyFlagClear, fetchValid, fetchShortForm, globalEnable} = 4'h0;
      {sleeping, ackOn, ackDelay, extFlagClear} = '0;
      {extIrqPin, keyPin} = 8'hF7;
      {extLevel, keyLevel, processorPriorityLevel} = '0;
      fetchAddress = 20'h0_0000;
      extCfg = '0;
      matchCfg = '0;
      keyCfg = '{'{1'b1, 1'b1}, '{1'b1, 1'b0}, '{1'b1, 1'b0}, '{1'b1, 1'b0}};
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      tick(2);
      t_match();
      t_ext();
      t_pin4();
      t_key();
      finish_test();
   end
endmodule
bind ext_key_addr_match_irq irq_checker irq_checker_i (.ref_clk(ref_clk),
   .rst(rst), .extCfg(extCfg), .matchCfg(matchCfg),
   .fetchAddress(fetchAddress), .fetchValid(fetchValid),
   .fetchShortForm(fetchShortForm), .globalEnable(globalEnable),
   .processorPriorityLevel(processorPriorityLevel), .cpuAck(cpuAck),
   .sleeping(sleeping), .requestFlag(requestFlag), .grant(grant),
   .stackedAddress(stackedAddress), .wakeUp(wakeUp));
`default_nettype wire
